// *** inc/hwd_defines.vh ***
// Purpose: constants for the host activity watchdog
// Assumes: pclk at 40 MHz, 32-bit APB, one-word non-volatile settings store
// Notes: one rule a line, tag first
// Function
// - timer runs only while any action enabled
// - every host transfer restarts timer from zero
// - reaching period fires all selected actions
// - actions: device reset, one line, or both
// - accept enable or disable configuration request
// - enable period limited to 3..65535 seconds
// - settings kept non-volatile, reloaded after reset
// - each accepted config request erases then writes store
// - line level one drives high, zero low
// - jumper short at power-up restores factory defaults
`ifndef HWD_DEFINES_VH
`define HWD_DEFINES_VH

// register byte offsets
`define HWD_OFF_OPT 12'h000
`define HWD_OFF_PERIOD 12'h004
`define HWD_OFF_CMD 12'h008
`define HWD_OFF_STATUS 12'h00C
`define HWD_OFF_ACTIVE 12'h010
`define HWD_OFF_SECONDS 12'h014

// option register fields
`define HWD_OPT_RST 0
`define HWD_OPT_LINE 1
`define HWD_OPT_SEL_LO 2
`define HWD_OPT_SEL_HI 6
`define HWD_OPT_LVL 7
// command register fields
`define HWD_CMD_EN 0
`define HWD_CMD_DIS 1
// status register fields
`define HWD_ST_EN 0
`define HWD_ST_RUN 1
`define HWD_ST_BUSY 2
`define HWD_ST_ERR 3
`define HWD_ST_FACT 4
`define HWD_ST_CNT_LO 16

// stored settings word fields
`define HWD_W_PER_HI 15
`define HWD_W_RST 16
`define HWD_W_LINE 17
`define HWD_W_SEL_LO 18
`define HWD_W_SEL_HI 22
`define HWD_W_LVL 23
`define HWD_W_EN 24
`define HWD_W_MARK_LO 25
`define HWD_W_MARK 7'h00

// factory default and reset values
`define HWD_FACTORY_WORD 32'h00000000
`define HWD_OPT_RESET 8'h00
`define HWD_PERIOD_RESET 16'h0000
`define HWD_PERIOD_MIN 16'h0003

// non-volatile store commands
`define HWD_NV_READ 2'h0
`define HWD_NV_ERASE 2'h1
`define HWD_NV_WRITE 2'h2

// timing
`define HWD_CLK_HZ 40000000
`define HWD_CLK_MHZ 40
`define HWD_TICK_S 1
`define HWD_TICK_CYCLES (`HWD_TICK_S * `HWD_CLK_HZ)
`define HWD_STRAP_SETTLE_NS 2000
`define HWD_STRAP_CYCLES ((`HWD_STRAP_SETTLE_NS * `HWD_CLK_MHZ + 999) / 1000)

`endif

// *** hw/hwd_top.v ***
// Purpose: host activity watchdog with APB registers and non-volatile settings
// Assumes: host_xfer and nv_* come from logic on pclk; jumper pin is asynchronous
// Notes: options are staged in OPT/PERIOD, applied by a write to CMD
`timescale 1ns/1ps
`default_nettype none
`include "hwd_defines.vh"

module hwd_top #(
    parameter TICK_CYCLES = `HWD_TICK_CYCLES,
    parameter SEL_W = 5
)(
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire host_xfer,
    output reg nv_req,
    output reg [1:0] nv_cmd,
    output reg [31:0] nv_wdata,
    input wire nv_done,
    input wire [31:0] nv_rdata,
    input wire jumper_a_in,
    output reg jumper_b_out,
    output reg jumper_b_oe,
    output reg device_reset,
    output reg line_strobe,
    output reg [SEL_W-1:0] line_sel,
    output reg line_level
);

    localparam S_STRAP = 3'h0;
    localparam S_RD = 3'h1;
    localparam S_IDLE = 3'h2;
    localparam S_ERASE = 3'h3;
    localparam S_WRITE = 3'h4;

    // a full second at the real clock; benches shrink TICK_CYCLES
    localparam [31:0] TICK_LAST = TICK_CYCLES - 1;
    // pin b is held low this long before pin a is believed
    localparam [31:0] STRAP_N = `HWD_STRAP_CYCLES - 1;
    localparam [15:0] STRAP_LAST = STRAP_N[15:0];

    reg [2:0] state_q;
    reg [15:0] strap_cnt_q;
    reg jmp_s1_q;
    reg jmp_s2_q;
    reg factory_q;
    reg [7:0] opt_q;
    reg [15:0] period_q;
    reg [31:0] act_q;
    reg [31:0] presc_q;
    reg [15:0] secs_q;
    reg err_q;
    reg [15:0] exp_cnt_q;
    reg nv_issued_q;

    wire act_en = act_q[`HWD_W_EN];
    wire act_rst = act_q[`HWD_W_RST];
    wire act_line = act_q[`HWD_W_LINE];
    wire [15:0] act_per = act_q[`HWD_W_PER_HI:0];
    wire running = act_en & (act_rst | act_line);
    // also high during the boot reload, so an early config waits
    wire nv_busy = (state_q != S_IDLE);
    wire tick = running & (presc_q == TICK_LAST);
    // host traffic in the expiry cycle wins, so no late action
    wire expire = tick & ((secs_q + 16'h0001) >= act_per) & ~host_xfer;

    // one decode feeds the error answer and the write strobes
    function [5:0] reg_hit;
        input [11:0] a;
        begin
            reg_hit[0] = (a == `HWD_OFF_OPT);
            reg_hit[1] = (a == `HWD_OFF_PERIOD);
            reg_hit[2] = (a == `HWD_OFF_CMD);
            reg_hit[3] = (a == `HWD_OFF_STATUS);
            reg_hit[4] = (a == `HWD_OFF_ACTIVE);
            reg_hit[5] = (a == `HWD_OFF_SECONDS);
        end
    endfunction

    wire [5:0] hit = reg_hit(paddr);
    wire addr_ok = |hit;
    wire acc = psel & penable & ~pready;
    wire cmd_wr = pwrite & hit[2];
    wire cmd_en = cmd_wr & pwdata[`HWD_CMD_EN];
    wire cmd_dis = cmd_wr & pwdata[`HWD_CMD_DIS] & ~pwdata[`HWD_CMD_EN];
    // a config request waits in the access phase while the store is busy
    wire acc_go = acc & ~(cmd_wr & nv_busy);
    // writes land on the edge where the master sees pready, not earlier
    wire fin_wr = psel & penable & pready & pwrite;
    wire per_bad = period_q < `HWD_PERIOD_MIN;
    wire cfg_ok = fin_wr & (cmd_dis | (cmd_en & ~per_bad));
    // a refused enable changes nothing but the error flag
    wire cfg_bad = fin_wr & cmd_en & per_bad;

    // settings word built from the staged options
    function [31:0] make_word;
        input en;
        input [7:0] opt;
        input [15:0] per;
        begin
            make_word = 32'h00000000;
            make_word[`HWD_W_PER_HI:0] = per;
            make_word[`HWD_W_RST] = opt[`HWD_OPT_RST];
            make_word[`HWD_W_LINE] = opt[`HWD_OPT_LINE];
            make_word[`HWD_W_SEL_HI:`HWD_W_SEL_LO] = opt[`HWD_OPT_SEL_HI:`HWD_OPT_SEL_LO];
            make_word[`HWD_W_LVL] = opt[`HWD_OPT_LVL];
            make_word[`HWD_W_EN] = en;
        end
    endfunction

    // an erased or foreign word must never arm the watchdog
    function word_ok;
        input [31:0] w;
        begin
            word_ok = (w[31:`HWD_W_MARK_LO] == `HWD_W_MARK)
                & (~w[`HWD_W_EN] | (w[`HWD_W_PER_HI:0] >= `HWD_PERIOD_MIN));
        end
    endfunction

    reg [31:0] rdata_d;
    always @*
    begin
        rdata_d = 32'h00000000;
        case (paddr)
            `HWD_OFF_OPT: rdata_d[7:0] = opt_q;
            `HWD_OFF_PERIOD: rdata_d[15:0] = period_q;
            `HWD_OFF_STATUS:
            begin
                rdata_d[`HWD_ST_EN] = act_en;
                rdata_d[`HWD_ST_RUN] = running;
                rdata_d[`HWD_ST_BUSY] = nv_busy;
                rdata_d[`HWD_ST_ERR] = err_q;
                rdata_d[`HWD_ST_FACT] = factory_q;
                rdata_d[31:`HWD_ST_CNT_LO] = exp_cnt_q;
            end
            `HWD_OFF_ACTIVE: rdata_d = act_q;
            `HWD_OFF_SECONDS: rdata_d[15:0] = secs_q;
            default: rdata_d = 32'h00000000;
        endcase
    end

    // apb slave: one wait state, longer while a config request meets a busy store
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
            opt_q <= `HWD_OPT_RESET;
            period_q <= `HWD_PERIOD_RESET;
        end
        else
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            if (acc_go)
            begin
                pready <= 1'b1;
                pslverr <= ~addr_ok | (cmd_en & per_bad);
                // read data stands with pready, the one cycle the master looks
                prdata <= pwrite ? 32'h00000000 : rdata_d;
            end
            // options only stage here; the active set moves on CMD
            if (fin_wr && hit[0])
                opt_q <= pwdata[7:0];
            if (fin_wr && hit[1])
                period_q <= pwdata[15:0];
        end
    end

    // jumper pin passes two flops before anything looks at it
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            jmp_s1_q <= 1'b1;
            jmp_s2_q <= 1'b1;
        end
        else
        begin
            jmp_s1_q <= jumper_a_in;
            jmp_s2_q <= jmp_s1_q;
        end
    end

    // settings store sequencer: strap check, reload, erase then write
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= S_STRAP;
            strap_cnt_q <= 16'h0000;
            factory_q <= 1'b0;
            act_q <= `HWD_FACTORY_WORD;
            nv_req <= 1'b0;
            nv_cmd <= `HWD_NV_READ;
            nv_wdata <= 32'h00000000;
            nv_issued_q <= 1'b0;
            jumper_b_out <= 1'b0;
            jumper_b_oe <= 1'b1;
            err_q <= 1'b0;
        end
        else
        begin
            nv_req <= 1'b0;
            if (cfg_bad)
                err_q <= 1'b1;
            else if (cfg_ok)
                err_q <= 1'b0;
            case (state_q)
                S_STRAP:
                begin
                    // pin b pulls low; a short shows up as pin a low
                    strap_cnt_q <= strap_cnt_q + 16'h0001;
                    if (strap_cnt_q == STRAP_LAST)
                    begin
                        jumper_b_oe <= 1'b0;
                        nv_issued_q <= 1'b0;
                        if (!jmp_s2_q)
                        begin
                            factory_q <= 1'b1;
                            act_q <= `HWD_FACTORY_WORD;
                            nv_wdata <= `HWD_FACTORY_WORD;
                            state_q <= S_ERASE;
                        end
                        else
                            state_q <= S_RD;
                    end
                end
                S_RD:
                begin
                    if (!nv_issued_q)
                    begin
                        nv_req <= 1'b1;
                        nv_cmd <= `HWD_NV_READ;
                        nv_issued_q <= 1'b1;
                    end
                    else if (nv_done)
                    begin
                        act_q <= word_ok(nv_rdata) ? nv_rdata : `HWD_FACTORY_WORD;
                        nv_issued_q <= 1'b0;
                        state_q <= S_IDLE;
                    end
                end
                S_IDLE:
                begin
                    if (cfg_ok)
                    begin
                        act_q <= make_word(cmd_en, opt_q, period_q);
                        nv_wdata <= make_word(cmd_en, opt_q, period_q);
                        nv_issued_q <= 1'b0;
                        state_q <= S_ERASE;
                    end
                end
                S_ERASE:
                begin
                    if (!nv_issued_q)
                    begin
                        nv_req <= 1'b1;
                        nv_cmd <= `HWD_NV_ERASE;
                        nv_issued_q <= 1'b1;
                    end
                    else if (nv_done)
                    begin
                        nv_issued_q <= 1'b0;
                        state_q <= S_WRITE;
                    end
                end
                S_WRITE:
                begin
                    if (!nv_issued_q)
                    begin
                        nv_req <= 1'b1;
                        nv_cmd <= `HWD_NV_WRITE;
                        nv_issued_q <= 1'b1;
                    end
                    else if (nv_done)
                    begin
                        nv_issued_q <= 1'b0;
                        state_q <= S_IDLE;
                    end
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end

    // seconds timer; host traffic and reconfiguration start it over
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            presc_q <= 32'h00000000;
            secs_q <= 16'h0000;
        end
        else if (!running || host_xfer || cfg_ok || expire)
        begin
            presc_q <= 32'h00000000;
            secs_q <= 16'h0000;
        end
        else if (tick)
        begin
            presc_q <= 32'h00000000;
            secs_q <= secs_q + 16'h0001;
        end
        else
            presc_q <= presc_q + 32'h00000001;
    end

    // timeout actions; direction of the line stays with whoever owns it
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            device_reset <= 1'b0;
            line_strobe <= 1'b0;
            line_sel <= {SEL_W{1'b0}};
            line_level <= 1'b0;
            exp_cnt_q <= 16'h0000;
        end
        else
        begin
            device_reset <= expire & act_rst;
            line_strobe <= expire & act_line;
            if (expire)
                exp_cnt_q <= exp_cnt_q + 16'h0001;
            if (expire && act_line)
            begin
                line_sel <= act_q[`HWD_W_SEL_LO+SEL_W-1:`HWD_W_SEL_LO];
                line_level <= act_q[`HWD_W_LVL];
            end
        end
    end

endmodule
`default_nettype wire

// *** verif/hwd_nv_model.sv ***
// Purpose: behavioural settings store facing hwd_top
// Assumes: one word; cells keep their value across presetn
// Notes: answers alternate fast and slow; erase leaves all ones
`timescale 1ns/1ps
`default_nettype none
module hwd_nv_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic req,
    input wire logic [1:0] cmd,
    input wire logic [31:0] wdata,
    output logic done,
    output logic [31:0] rdata
);
    logic [31:0] mem_q = 32'h00000000;
    logic [2:0] cnt_q;
    logic slow_q = 1'b0;
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_q <= 3'h0;
            done <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            if (req)
            begin
                slow_q <= !slow_q;
                cnt_q <= slow_q ? 3'h6 : 3'h1;
            end
            else if (cnt_q != 3'h0)
                cnt_q <= cnt_q - 3'h1;
            if (!req && cnt_q == 3'h1)
            begin
                done <= 1'b1;
                if (cmd == 2'h1)
                    mem_q <= 32'hFFFFFFFF;
                if (cmd == 2'h2)
                    mem_q <= wdata;
            end
        end
    end
    // outside done the bus shows garbage, not the last word
    assign rdata = done ? mem_q : ~mem_q;
endmodule
`default_nettype wire

// *** verif/hwd_checker.sv ***
// Purpose: port assertions for hwd_top
// Assumes: TICK_CYCLES of at least 3
// Notes: bound into every hwd_top
`timescale 1ns/1ps
`default_nettype none
module hwd_checker #(
    parameter TICK_CYCLES = 10,
    parameter SEL_W = 5
)(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic host_xfer,
    input wire logic nv_req,
    input wire logic [1:0] nv_cmd,
    input wire logic jumper_a_in,
    input wire logic jumper_b_oe,
    input wire logic device_reset,
    input wire logic line_strobe,
    input wire logic [SEL_W-1:0] line_sel,
    input wire logic line_level
);
    logic [15:0] per_q;
    logic [1:0] last_q;
    wire done_w = psel && penable && pready;
    wire cmd_w = done_w && pwrite && paddr == 12'h008;
    // mirrors the period register, which resets to zero
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            per_q <= 16'h0000;
            last_q <= 2'h0;
        end
        else
        begin
            if (done_w && pwrite && paddr == 12'h004)
                per_q <= pwdata[15:0];
            if (nv_req)
                last_q <= nv_cmd;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence cmd_ok_s;
        cmd_w && !pslverr && pwdata[1:0] != 2'h0;
    endsequence
    sequence erase_s;
        nv_req && nv_cmd == 2'h1;
    endsequence
    err_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    short_per_a: assert property (cmd_w && pwdata[0] && per_q < 16'h0003 |-> pslverr)
        else $error("short period accepted");
    cmd_erase_a: assert property (cmd_ok_s |-> ##[1:4] erase_s)
        else $error("no erase after config");
    erase_write_a: assert property (nv_req && nv_cmd == 2'h2 |-> last_q == 2'h1)
        else $error("write without erase");
    boot_read_a: assert property ($fell(jumper_b_oe) && $past(jumper_a_in) |-> ##[0:3] nv_req && nv_cmd == 2'h0)
        else $error("no store read at boot");
    pulse_once_a: assert property (line_strobe || device_reset |=> !line_strobe && !device_reset)
        else $error("action longer than one cycle");
    xfer_quiet_a: assert property (host_xfer |=> (!line_strobe && !device_reset) [*8])
        else $error("action soon after host transfer");
    sel_hold_a: assert property (!line_strobe |-> $stable(line_sel) && $stable(line_level))
        else $error("line outputs moved without strobe");
endmodule
bind hwd_top hwd_checker #(.TICK_CYCLES(TICK_CYCLES), .SEL_W(SEL_W)) i_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .host_xfer(host_xfer),
    .nv_req(nv_req), .nv_cmd(nv_cmd), .jumper_a_in(jumper_a_in), .jumper_b_oe(jumper_b_oe),
    .device_reset(device_reset), .line_strobe(line_strobe), .line_sel(line_sel),
    .line_level(line_level));
`default_nettype wire

// *** verif/tb_top.sv ***
// Purpose: self-checking bench for hwd_top
// Assumes: short tick of 10 cycles
// Notes: jumper short pulls pin a low only while pin b drives
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int T = 10;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, host_xfer = 1'b0, short_q = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    wire [31:0] prdata, nv_wdata, nv_rdata;
    wire pready, pslverr, nv_req, nv_done, jumper_b_out, jumper_b_oe;
    wire device_reset, line_strobe, line_level;
    wire [1:0] nv_cmd;
    wire [4:0] line_sel;
    wire jumper_a_in = !(short_q && jumper_b_oe && !jumper_b_out);
    int num_errors = 0, num_checks = 0, acts = 0, n;
    logic [31:0] rd;
    logic er;
    hwd_top #(.TICK_CYCLES(T)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .host_xfer(host_xfer), .nv_req(nv_req),
        .nv_cmd(nv_cmd), .nv_wdata(nv_wdata), .nv_done(nv_done), .nv_rdata(nv_rdata),
        .jumper_a_in(jumper_a_in), .jumper_b_out(jumper_b_out), .jumper_b_oe(jumper_b_oe),
        .device_reset(device_reset), .line_strobe(line_strobe), .line_sel(line_sel),
        .line_level(line_level));
    hwd_nv_model i_nv (.clk(pclk), .rst_n(presetn), .req(nv_req), .cmd(nv_cmd),
        .wdata(nv_wdata), .done(nv_done), .rdata(nv_rdata));
    initial
        forever #12.5 pclk = ~pclk;
    always @(posedge pclk)
        if (line_strobe === 1'b1 || device_reset === 1'b1)
            acts++;
    task automatic final_report;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h00000000);
        chk(rd, exp);
    endtask
    task automatic cfg(input logic [7:0] o, input logic [15:0] p, input logic [1:0] c);
        apb(1'b1, 12'h000, {24'h000000, o});
        apb(1'b1, 12'h004, {16'h0000, p});
        apb(1'b1, 12'h008, {30'h00000000, c});
    endtask
    // bounded wait, n counts edges until an action is seen
    task automatic wait_act(input int p);
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (line_strobe !== 1'b1 && device_reset !== 1'b1 && n < 900);
        chk(32'(n > p * T - 4 && n < p * T + 5), 32'h1);
    endtask
    task automatic boot(input logic s);
        short_q <= s;
        presetn <= 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        repeat (120) @(posedge pclk);
        short_q <= 1'b0;
    endtask
    task automatic t_regs;
        rdchk(12'h000, 32'h00000000);
        apb(1'b1, 12'h000, 32'h000000AB);
        rdchk(12'h000, 32'h000000AB);
        rdchk(12'h010, 32'h00000000);
        rdchk(12'h018, 32'h00000000);
        chk(er, 1'b1);
        apb(1'b1, 12'h004, 32'h00000002);
        apb(1'b1, 12'h008, 32'h00000001);
        chk(er, 1'b1);
        rdchk(12'h010, 32'h00000000);
        apb(1'b0, 12'h00C, 32'h00000000);
        chk(rd[3], 1'b1);
        $display("done regs");
    endtask
    task automatic t_line;
        cfg(8'hAA, 16'h0003, 2'h1);
        chk(er, 1'b0);
        wait_act(3);
        chk({device_reset, line_strobe, line_level, line_sel}, {3'h3, 5'h0A});
        wait_act(3);
        rdchk(12'h010, {7'h00, 1'b1, 1'b1, 5'h0A, 1'b1, 1'b0, 16'h0003});
        apb(1'b0, 12'h00C, 32'h00000000);
        chk(rd[31:16], 16'h0002);
        n = acts;
        repeat (8)
        begin
            host_xfer <= 1'b1;
            @(posedge pclk);
            host_xfer <= 1'b0;
            repeat (20) @(posedge pclk);
        end
        chk(acts - n, 0);
        host_xfer <= 1'b1;
        @(posedge pclk);
        host_xfer <= 1'b0;
        wait_act(3);
        $display("done line");
    endtask
    task automatic t_both;
        cfg(8'h0F, 16'h0004, 2'h1);
        wait_act(4);
        chk({device_reset, line_strobe, line_level, line_sel}, {3'h6, 5'h03});
        boot(1'b0);
        rdchk(12'h010, {7'h00, 1'b1, 1'b0, 5'h03, 1'b1, 1'b1, 16'h0004});
        $display("done both");
    endtask
    task automatic t_off;
        cfg(8'h0F, 16'h0004, 2'h2);
        chk(er, 1'b0);
        n = acts;
        repeat (150) @(posedge pclk);
        cfg(8'h00, 16'h0003, 2'h3);
        repeat (150) @(posedge pclk);
        chk(acts - n, 0);
        rdchk(12'h014, 32'h00000000);
        rdchk(12'h010, {7'h00, 1'b1, 1'b0, 5'h00, 1'b0, 1'b0, 16'h0003});
        boot(1'b1);
        rdchk(12'h010, 32'h00000000);
        apb(1'b0, 12'h00C, 32'h00000000);
        chk(rd[4], 1'b1);
        $display("done off");
    endtask
    initial
    begin
        boot(1'b0);
        t_regs();
        t_line();
        t_both();
        t_off();
        final_report();
    end
    initial
    begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        $display("BAD %0t timeout", $time);
        final_report();
    end
endmodule
`default_nettype wire
